//--- ruc_map.vh
// Functional notes
// [R1] Divisor is int(clock/baud+0.5), period divisor+1.
// [R2] Baud fixed at build; no register changes it.
// [R3] Character width 7, 8 or 9 bits.
// [R4] Transmit one or two stop bits.
// [R5] Receiver ends at first stop bit.
// [R6] No parity: none sent, none expected.
// [R7] No parity: error flag reads zero.
// [R8] Odd/even: insert parity, check received parity.
// [R9] Even: one on even ones; odd: odd ones.
// [R10] Data at byte 0, control at byte 4.
// [R11] Data word: char, error, valid, fill count.
// [R12] Data read pops oldest, count includes it.
// [R13] Data write pushes; full FIFO drops character.
// [R14] Reserved bits undefined; master writes zero.
// [R15] Absent data bits read zero, ignore writes.
// [R16] Control bits 0,1 are interrupt enables.
// [R17] Control bits 8,9 are pending flags.
// [R18] Control bits 23:16 give transmit free space.
// [R19] Pending flags gated by enables drive request.
// [R20] Build with register port or streaming ports.
// [R21] Sources: receive not empty, transmit not full.
// [R22] Idle high, start low, LSB first, stops high.
// [R23] Empty read returns valid clear, no change.
`ifndef RUC_MAP_VH
`define RUC_MAP_VH
`define RUC_OFS_DATA   3'h0
`define RUC_OFS_CTRL   3'h4
`define RUC_DATA_PERR  9
`define RUC_DATA_VALID 15
`define RUC_CNT_LSB    16
`define RUC_CTRL_RXEN  0
`define RUC_CTRL_TXEN  1
`define RUC_CTRL_RXPND 8
`define RUC_CTRL_TXPND 9
`define RUC_PAR_NONE   0
`define RUC_PAR_EVEN   1
`define RUC_PAR_ODD    2
`define RUC_CLK_HZ     25000000
`define RUC_BAUD       115200
`define RUC_RST_LINE   1'b1
`define RUC_RST_EN     1'b0
`endif

//--- ruc_core.v
`timescale 1ns/1ps
`default_nettype none
`include "ruc_map.vh"
module ruc_core #(
  parameter CLK_HZ    = `RUC_CLK_HZ,
  parameter BAUD      = `RUC_BAUD,
  parameter DATA_W    = 8,
  parameter STOP_BITS = 1,
  parameter PARITY    = `RUC_PAR_NONE,
  parameter FIFO_AW   = 7,
  parameter STREAM    = 0
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire [2:0]        address_i,
  input  wire              chipselect_i,
  input  wire              read_i,
  input  wire              write_i,
  input  wire [31:0]       writedata_i,
  output reg  [31:0]       readdata_o,
  output reg               irq_o,
  input  wire              rxd_i,
  output reg               txd_o,
  input  wire [DATA_W-1:0] tx_stream_data_i,
  input  wire              tx_stream_valid_i,
  output reg               tx_stream_ready_o,
  output reg  [DATA_W-1:0] rx_stream_data_o,
  output reg               rx_stream_perr_o,
  output reg               rx_stream_valid_o,
  input  wire              rx_stream_ready_i
);

  // Divisor rounds to nearest; one bit lasts divisor+1 clocks.
  localparam integer DIVISOR = (2 * CLK_HZ + BAUD) / (2 * BAUD); // [R1] [R2]
  localparam [15:0]  DIV     = DIVISOR[15:0];
  localparam [15:0]  HALF    = DIV >> 1;
  localparam integer PB      = (PARITY != `RUC_PAR_NONE) ? 1 : 0;
  localparam integer PAY_W   = DATA_W + PB + STOP_BITS;
  localparam integer CW      = FIFO_AW + 1;
  localparam [CW-1:0] DEPTH  = {1'b1, {FIFO_AW{1'b0}}};
  localparam [CW-1:0] CNT_0  = {CW{1'b0}};

  localparam [2:0] RX_IDLE  = 3'h0;
  localparam [2:0] RX_START = 3'h1;
  localparam [2:0] RX_BITS  = 3'h2;
  localparam [2:0] RX_PAR   = 3'h3;
  localparam [2:0] RX_STOP  = 3'h4;

  function par_bit;
    input [DATA_W-1:0] d;
    begin
      if (PARITY == `RUC_PAR_EVEN)
        par_bit = ~^d; // [R9]
      else
        par_bit = ^d; // [R9]
    end
  endfunction

  reg  [DATA_W-1:0] tx_mem [0:(1<<FIFO_AW)-1];
  reg  [DATA_W:0]   rx_mem [0:(1<<FIFO_AW)-1];
  reg  [FIFO_AW-1:0] tx_wr;
  reg  [FIFO_AW-1:0] tx_rd;
  reg  [CW-1:0]      tx_count;
  reg  [FIFO_AW-1:0] rx_wr;
  reg  [FIFO_AW-1:0] rx_rd;
  reg  [CW-1:0]      rx_count;
  reg                rx_en;
  reg                tx_en;
  reg                tx_busy;
  reg  [PAY_W-1:0]   tx_shift;
  reg  [3:0]         tx_left;
  reg  [15:0]        tx_baud;
  reg                rx_s1;
  reg                rx_s2;
  reg                rx_s3;
  reg                rx_line;
  reg  [2:0]         rx_state;
  reg  [15:0]        rx_baud;
  reg  [3:0]         rx_idx;
  reg  [DATA_W-1:0]  rx_data;
  reg                rx_par;
  reg                rx_push;
  reg                rx_perr;
  reg  [31:0]        rd_word;
  reg  [CW-1:0]      next_tx_count;

  wire acc_data = chipselect_i && (address_i == `RUC_OFS_DATA); // [R10]
  wire acc_ctrl = chipselect_i && (address_i == `RUC_OFS_CTRL); // [R10]
  wire rd_data  = acc_data && read_i;
  wire wr_data  = acc_data && write_i;
  wire wr_ctrl  = acc_ctrl && write_i;
  wire tx_full  = (tx_count == DEPTH);
  wire rx_full  = (rx_count == DEPTH);
  wire rx_some  = (rx_count != CNT_0);

  wire [DATA_W-1:0] tx_head = tx_mem[tx_rd];
  wire [DATA_W:0]   rx_head = rx_mem[rx_rd];
  wire [CW-1:0]     tx_room = DEPTH - tx_count;

  // Only one host interface feeds the FIFOs, chosen at build time.
  wire stream_load = rx_some && (!rx_stream_valid_o || rx_stream_ready_i);
  wire tx_push = (STREAM != 0) ? (tx_stream_valid_i && tx_stream_ready_o) // [R20]
                               : (wr_data && !tx_full); // [R13]
  wire rx_pop  = (STREAM != 0) ? stream_load // [R20]
                               : (rd_data && rx_some); // [R12] [R23]
  wire tx_pop  = !tx_busy && (tx_count != CNT_0);
  wire rx_in   = rx_push && !rx_full;
  wire [DATA_W-1:0] tx_in = (STREAM != 0) ? tx_stream_data_i
                                          : writedata_i[DATA_W-1:0]; // [R15]

  wire rx_src  = rx_some; // [R21]
  wire tx_src  = !tx_full; // [R21]
  wire rx_pend = rx_src && rx_en; // [R19]
  wire tx_pend = tx_src && tx_en; // [R19]

  wire [PAY_W-1:0] tx_payload;
  generate
    if (PB != 0)
    begin : g_par
      assign tx_payload = {{STOP_BITS{1'b1}}, par_bit(tx_head), tx_head}; // [R8] [R4]
    end
    else
    begin : g_nopar
      assign tx_payload = {{STOP_BITS{1'b1}}, tx_head}; // [R6] [R4]
    end
  endgenerate

  always @*
  begin
    next_tx_count = tx_count;
    if (tx_push && !tx_pop)
      next_tx_count = tx_count + 1'b1;
    else if (!tx_push && tx_pop)
      next_tx_count = tx_count - 1'b1;
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_wr    <= {FIFO_AW{1'b0}};
      tx_rd    <= {FIFO_AW{1'b0}};
      tx_count <= CNT_0;
      tx_stream_ready_o <= 1'b0;
    end
    else
    begin
      if (tx_push)
        tx_wr <= tx_wr + 1'b1;
      if (tx_pop)
        tx_rd <= tx_rd + 1'b1;
      tx_count <= next_tx_count;
      // Ready reflects the count after this edge, so no word is lost.
      tx_stream_ready_o <= (STREAM != 0) && (next_tx_count != DEPTH);
    end
  end

  always @(posedge clk_i)
  begin
    if (tx_push)
      tx_mem[tx_wr] <= tx_in;
    if (rx_in)
      rx_mem[rx_wr] <= {rx_perr, rx_data};
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_busy  <= 1'b0;
      txd_o    <= `RUC_RST_LINE;
      tx_shift <= {PAY_W{1'b1}};
      tx_left  <= 4'h0;
      tx_baud  <= 16'h0000;
    end
    else if (!tx_busy)
    begin
      txd_o <= 1'b1; // [R22]
      if (tx_pop)
      begin
        tx_busy  <= 1'b1;
        txd_o    <= 1'b0; // [R22]
        tx_shift <= tx_payload;
        tx_left  <= PAY_W[3:0];
        tx_baud  <= 16'h0000;
      end
    end
    else if (tx_baud == DIV) // [R1]
    begin
      tx_baud <= 16'h0000;
      if (tx_left == 4'h0)
        tx_busy <= 1'b0;
      else
      begin
        txd_o    <= tx_shift[0]; // [R22]
        tx_shift <= {1'b1, tx_shift[PAY_W-1:1]};
        tx_left  <= tx_left - 1'b1;
      end
    end
    else
      tx_baud <= tx_baud + 1'b1;
  end

  // Three stages; the line level moves only when the last two agree.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_s1   <= `RUC_RST_LINE;
      rx_s2   <= `RUC_RST_LINE;
      rx_s3   <= `RUC_RST_LINE;
      rx_line <= `RUC_RST_LINE;
    end
    else
    begin
      rx_s1 <= rxd_i;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3)
        rx_line <= rx_s3;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_state <= RX_IDLE;
      rx_baud  <= 16'h0000;
      rx_idx   <= 4'h0;
      rx_data  <= {DATA_W{1'b0}};
      rx_par   <= 1'b0;
      rx_push  <= 1'b0;
      rx_perr  <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      rx_baud <= rx_baud + 1'b1;
      case (rx_state)
        RX_IDLE:
        begin
          rx_baud <= 16'h0000;
          if (!rx_line)
            rx_state <= RX_START; // [R22]
        end
        RX_START:
          if (rx_baud == HALF)
          begin
            // A glitch shorter than half a bit is rejected here.
            rx_baud  <= 16'h0000;
            rx_idx   <= 4'h0;
            rx_state <= rx_line ? RX_IDLE : RX_BITS;
          end
        RX_BITS:
          if (rx_baud == DIV)
          begin
            rx_baud <= 16'h0000;
            rx_data <= {rx_line, rx_data[DATA_W-1:1]}; // [R22] [R3]
            rx_idx  <= rx_idx + 1'b1;
            if (rx_idx == DATA_W - 1)
              rx_state <= (PB != 0) ? RX_PAR : RX_STOP; // [R6]
          end
        RX_PAR:
          if (rx_baud == DIV)
          begin
            rx_baud  <= 16'h0000;
            rx_par   <= rx_line; // [R8]
            rx_state <= RX_STOP;
          end
        RX_STOP:
          if (rx_baud == DIV)
          begin
            // Extra stop bits fall into idle and are never sampled.
            rx_push  <= 1'b1; // [R5]
            rx_perr  <= (PB != 0) && (rx_par != par_bit(rx_data)); // [R7] [R8]
            rx_state <= RX_IDLE; // [R5]
          end
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_wr    <= {FIFO_AW{1'b0}};
      rx_rd    <= {FIFO_AW{1'b0}};
      rx_count <= CNT_0;
    end
    else
    begin
      if (rx_in)
        rx_wr <= rx_wr + 1'b1;
      if (rx_pop)
        rx_rd <= rx_rd + 1'b1; // [R12]
      if (rx_in && !rx_pop)
        rx_count <= rx_count + 1'b1;
      else if (!rx_in && rx_pop)
        rx_count <= rx_count - 1'b1;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_stream_data_o  <= {DATA_W{1'b0}};
      rx_stream_perr_o  <= 1'b0;
      rx_stream_valid_o <= 1'b0;
    end
    else if (STREAM != 0)
    begin
      if (stream_load)
      begin
        rx_stream_data_o  <= rx_head[DATA_W-1:0];
        rx_stream_perr_o  <= rx_head[DATA_W];
        rx_stream_valid_o <= 1'b1;
      end
      else if (rx_stream_ready_i)
        rx_stream_valid_o <= 1'b0;
    end
  end

  // Reserved and absent bits are returned as zero.
  always @*
  begin
    rd_word = 32'h0000_0000; // [R14] [R15]
    if (acc_data && rx_some)
    begin
      rd_word[DATA_W-1:0]             = rx_head[DATA_W-1:0]; // [R11]
      rd_word[`RUC_DATA_PERR]         = rx_head[DATA_W]; // [R11] [R7]
      rd_word[`RUC_DATA_VALID]        = 1'b1; // [R11] [R23]
      rd_word[`RUC_CNT_LSB +: CW]     = rx_count; // [R12]
    end
    else if (acc_ctrl)
    begin
      rd_word[`RUC_CTRL_RXEN]         = rx_en; // [R16]
      rd_word[`RUC_CTRL_TXEN]         = tx_en; // [R16]
      rd_word[`RUC_CTRL_RXPND]        = rx_pend; // [R17]
      rd_word[`RUC_CTRL_TXPND]        = tx_pend; // [R17]
      rd_word[`RUC_CNT_LSB +: CW]     = tx_room; // [R18]
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      readdata_o <= 32'h0000_0000;
      rx_en      <= `RUC_RST_EN;
      tx_en      <= `RUC_RST_EN;
      irq_o      <= 1'b0;
    end
    else
    begin
      if (chipselect_i && read_i)
        readdata_o <= rd_word;
      if (wr_ctrl)
      begin
        rx_en <= writedata_i[`RUC_CTRL_RXEN]; // [R16]
        tx_en <= writedata_i[`RUC_CTRL_TXEN]; // [R16]
      end
      irq_o <= rx_pend || tx_pend; // [R19]
    end
  end

endmodule
`default_nettype wire

//--- ruc_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ruc_core_chk #(
  parameter CLK_HZ = 25000000,
  parameter BAUD   = 115200
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [2:0]  address_i,
  input wire logic        chipselect_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic        irq_o,
  input wire logic        txd_o,
  input wire logic        tx_stream_ready_o,
  input wire logic        rx_stream_valid_o
);
  localparam int BIT = (CLK_HZ * 2 / BAUD + 1) / 2 + 1;
  logic [1:0]  en;
  logic        prev;
  logic [15:0] run;
  wire rd = chipselect_i && read_i;
  wire wr = chipselect_i && write_i;
  // Shadow of the enables and the length of the current line level, built from inputs only.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      en   <= 2'h0;
      prev <= 1'b1;
      run  <= 16'h0;
    end
    else
    begin
      if (wr && address_i == 3'h4)
        en <= writedata_i[1:0];
      prev <= txd_o;
      run  <= (txd_o != prev) ? 16'h1 : run + 16'h1;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  unmapped_read_a: assert property (rd && address_i[1:0] != 2'h0 |=> readdata_o == 32'h0)
    else $error("unmapped read not zero");
  enable_readback_a: assert property (rd && address_i == 3'h4 |=> readdata_o[1:0] == en)
    else $error("enable bits differ");
  pend_gate_a: assert property (rd && address_i == 3'h4 |=>
    (!readdata_o[8] || en[0]) && (!readdata_o[9] || en[1]))
    else $error("pending flag without enable");
  tx_pend_a: assert property (rd && address_i == 3'h4 |=>
    readdata_o[9] == (en[1] && readdata_o[23:16] != 8'h0))
    else $error("transmit pending wrong");
  data_valid_a: assert property (rd && address_i == 3'h0 |=>
    readdata_o[15] == (readdata_o[23:16] != 8'h0))
    else $error("valid flag and count disagree");
  stream_idle_a: assert property (!tx_stream_ready_o && !rx_stream_valid_o)
    else $error("stream port active in register mode");
  // Every low run ends on a bit boundary, so its length is a whole number of bit times.
  bit_time_a: assert property (txd_o && !prev |-> run % BIT == 0)
    else $error("bit time wrong");
  reset_idle_a: assert property ($fell(rst_i) |-> txd_o && !irq_o)
    else $error("not idle after reset");
  irq_off_a: assert property (en == 2'h0 && $past(en) == 2'h0 |-> !irq_o)
    else $error("request while disabled");
  cover property (rd && address_i == 3'h0 ##1 readdata_o[15]);
  cover property (txd_o && !prev);
  cover property (irq_o);
endmodule
`default_nettype wire

//--- ruc_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ruc_peer #(
  parameter int BIT = 26
) (
  input  wire logic txd_i,
  output var  logic rxd_o
);
  localparam int T = BIT * 40;
  logic [7:0] got_char;
  logic       got_par;
  logic [1:0] got_stop;
  int         got_count;
  initial
  begin
    rxd_o = 1'b1;
    got_count = 0;
  end
  // Sends one stop bit only, so a back-to-back start lands where a second stop would be.
  task automatic send(input logic [7:0] d, input logic flip);
    logic [9:0] f;
    f = {~^d ^ flip, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_o <= f[i];
      #(T);
    end
    rxd_o <= 1'b1;
    #(T);
  endtask
  always
  begin
    @(negedge txd_i);
    #(T / 2);
    for (int i = 0; i < 8; i++)
    begin
      #(T);
      got_char[i] = txd_i;
    end
    #(T);
    got_par = txd_i;
    #(T);
    got_stop[0] = txd_i;
    #(T);
    got_stop[1] = txd_i;
    got_count++;
  end
endmodule
`default_nettype wire

//--- ruc_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ruc_map.vh"
module ruc_core_test;
  localparam int BIT = 26;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  address_i = 3'h0;
  logic        chipselect_i = 1'b0;
  logic        lb_cs = 1'b0;
  logic        lb_sel = 1'b0;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [31:0] d;
  wire  [31:0] readdata_o;
  wire  [31:0] lb_rdata;
  wire         irq_o;
  wire         rxd;
  wire         lb_line;
  wire         txd_o;
  wire         tx_stream_ready_o;
  wire         rx_stream_valid_o;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  ruc_core #(.BAUD(1000000), .STOP_BITS(2), .PARITY(`RUC_PAR_EVEN)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i),
    .chipselect_i(chipselect_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .irq_o(irq_o),
    .rxd_i(rxd), .txd_o(txd_o), .tx_stream_data_i(8'h00),
    .tx_stream_valid_i(1'b0), .tx_stream_ready_o(tx_stream_ready_o),
    .rx_stream_data_o(), .rx_stream_perr_o(),
    .rx_stream_valid_o(rx_stream_valid_o), .rx_stream_ready_i(1'b0));
  ruc_peer #(.BIT(BIT)) peer (.txd_i(txd_o), .rxd_o(rxd));
  // Second core without parity and with seven data bits, its line looped back.
  ruc_core #(.BAUD(1000000), .DATA_W(7), .PARITY(`RUC_PAR_NONE)) dut_lb (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i),
    .chipselect_i(lb_cs), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .readdata_o(lb_rdata), .irq_o(),
    .rxd_i(lb_line), .txd_o(lb_line), .tx_stream_data_i(7'h00),
    .tx_stream_valid_i(1'b0), .tx_stream_ready_o(),
    .rx_stream_data_o(), .rx_stream_perr_o(),
    .rx_stream_valid_o(), .rx_stream_ready_i(1'b0));
  initial
    forever #20 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reserved write bits are always sent as zero; read data lands one cycle after the strobe.
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    chipselect_i <= !lb_sel;
    lb_cs <= lb_sel;
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= wd;
    @(posedge clk_i);
    chipselect_i <= 1'b0;
    lb_cs <= 1'b0;
    read_i <= 1'b0;
    write_i <= 1'b0;
    #1 d = lb_sel ? lb_rdata : readdata_o;
  endtask
  task automatic wait_peer(input int n);
    for (int i = 0; i < 2000 && peer.got_count < n; i++)
      @(posedge clk_i);
  endtask
  task automatic test_regs;
    bus(1'b0, `RUC_OFS_CTRL, 32'h0);
    chk(d, 32'h0080_0000);
    bus(1'b1, `RUC_OFS_CTRL, 32'h3);
    bus(1'b0, `RUC_OFS_CTRL, 32'h0);
    chk(d, 32'h0080_0203);
    bus(1'b0, 3'h6, 32'h0);
    chk(d, 32'h0);
    bus(1'b0, `RUC_OFS_DATA, 32'h0);
    chk(d, 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_tx;
    bus(1'b1, `RUC_OFS_DATA, 32'h1A5);
    bus(1'b1, `RUC_OFS_DATA, 32'h001);
    wait_peer(1);
    chk(peer.got_char, 32'hA5);
    chk(peer.got_par, 32'h1);
    chk(peer.got_stop, 32'h3);
    wait_peer(2);
    chk(peer.got_char, 32'h01);
    chk(peer.got_par, 32'h0);
    $display("test_tx done");
  endtask
  task automatic test_rx;
    peer.send(8'h5A, 1'b0);
    peer.send(8'h3C, 1'b1);
    repeat (3 * BIT) @(posedge clk_i);
    bus(1'b0, `RUC_OFS_CTRL, 32'h0);
    chk(d, 32'h0080_0303);
    bus(1'b1, `RUC_OFS_CTRL, 32'h1);
    bus(1'b0, `RUC_OFS_CTRL, 32'h0);
    chk(d, 32'h0080_0101);
    chk(irq_o, 32'h1);
    bus(1'b0, `RUC_OFS_DATA, 32'h0);
    chk(d, 32'h0002_805A);
    bus(1'b0, `RUC_OFS_DATA, 32'h0);
    chk(d, 32'h0001_823C);
    bus(1'b0, `RUC_OFS_DATA, 32'h0);
    chk(d, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk(irq_o, 32'h0);
    $display("test_rx done");
  endtask
  // Bits above the seven data bits are dropped on write and read back as zero.
  task automatic test_loop;
    lb_sel = 1'b1;
    bus(1'b1, `RUC_OFS_DATA, 32'h1FF);
    repeat (10 * BIT) @(posedge clk_i);
    bus(1'b0, `RUC_OFS_DATA, 32'h0);
    chk(d, 32'h0001_807F);
    bus(1'b0, `RUC_OFS_DATA, 32'h0);
    chk(d, 32'h0);
    lb_sel = 1'b0;
    $display("test_loop done");
  endtask
  // The first character is still on the line, so 129 writes fill the queue and one more is lost.
  task automatic test_fill;
    bus(1'b1, `RUC_OFS_CTRL, 32'h2);
    repeat (130) bus(1'b1, `RUC_OFS_DATA, 32'h55);
    bus(1'b0, `RUC_OFS_CTRL, 32'h0);
    chk(d, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    #1 chk(irq_o, 32'h0);
    $display("test_fill done");
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs;
    test_tx;
    test_rx;
    test_loop;
    test_fill;
    finish_test;
  end
endmodule
bind ruc_core ruc_core_chk #(.CLK_HZ(CLK_HZ), .BAUD(BAUD)) prot_chk (
  .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i),
  .chipselect_i(chipselect_i), .read_i(read_i), .write_i(write_i),
  .writedata_i(writedata_i), .readdata_o(readdata_o), .irq_o(irq_o),
  .txd_o(txd_o), .tx_stream_ready_o(tx_stream_ready_o),
  .rx_stream_valid_o(rx_stream_valid_o));
`default_nettype wire
